// file: verilog/upc_pkg.sv
package upc_pkg;
  localparam logic [7:0]  PWR_SIG_OFS   = 8'h3C;
  localparam logic [7:0]  PHY_CTRL_OFS  = 8'h40;
  localparam logic [7:0]  IRQ_STAT_OFS  = 8'h44;
  localparam logic [7:0]  IRQ_MASK_OFS  = 8'h48;
  localparam logic [7:0]  LINE_STAT_OFS = 8'h4C;
  localparam int          PS_VALID_BIT  = 8;
  localparam int          PD_OFF_BIT    = 18;
  localparam int          SE0_FLAG_BIT  = 13;
  localparam int          K_FLAG_BIT    = 12;
  localparam int          DLY_LSB       = 8;
  localparam int          HW_RESUME_BIT = 7;
  localparam int          CONF_LSB      = 4;
  localparam logic [31:0] PWR_SIG_MASK  = 32'h0000_01FF;
  localparam logic [31:0] PHY_CTRL_MASK = 32'h0004_3FF0;
  localparam logic [31:0] RESET_VAL     = 32'h0000_0000;
  localparam logic [1:0]  LS_SE0        = 2'h0;
  localparam logic [1:0]  LS_J          = 2'h1;
  localparam logic [1:0]  LS_K          = 2'h2;
  localparam logic [1:0]  IRQ_SE0       = 2'h0;
  localparam int          IRQ_W         = 2;
endpackage

// file: verilog/upc_line_if.sv
interface upc_line_if;
  logic [1:0] lineRaw;
  logic [3:0] delayLog2;
  logic [1:0] lineFilt;
  logic       lineChange;
  modport ctrl (output lineRaw, output delayLog2, input lineFilt,
                input lineChange);
  modport filt (input lineRaw, input delayLog2, output lineFilt,
                output lineChange);
endinterface

// file: verilog/upc_line_filter.sv
module upc_line_filter (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // line state
  upc_line_if.filt lf
);
  logic [15:0] cnt_r;
  logic [1:0]  filt_r;
  logic [1:0]  cand_r;
  logic        chg_r;
  logic [15:0] target;

  // 2**n cycles; the count restarts if the raw state moves again
  assign target = 16'(16'h0001 << lf.delayLog2);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 16'h0000;
      // start at the idle level so reset gives no false change
      cand_r <= upc_pkg::LS_J;
      filt_r <= upc_pkg::LS_J;
      chg_r  <= 1'b0;
    end else begin
      chg_r <= 1'b0;
      if (lf.lineRaw != cand_r) begin
        cand_r <= lf.lineRaw;
        cnt_r  <= 16'h0001;
      end else if (cand_r != filt_r) begin
        if (cnt_r >= target) begin
          filt_r <= cand_r;
          chg_r  <= 1'b1;
        end else begin
          cnt_r <= 16'(cnt_r + 16'h0001);
        end
      end
    end
  end

  assign lf.lineFilt   = filt_r;
  assign lf.lineChange = chg_r;
endmodule

// file: verilog/upc_regs.sv
// Operation
// - bit 18 set disables both port pulldowns
// - SE0 auto-resume sets bit 13, software clears
// - K auto-resume sets bit 12, software clears
// - line change delayed two-power bits 11:8
// - bit 7 selects hardware or polled resume
// - bits 6:4 drive transceiver config pins
module upc_regs (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // transceiver side
  input  wire logic [1:0]  lineStateRaw,
  input  wire logic        suspended,
  output logic             resumeReq,
  output logic             pulldownOffFirstBytePort,
  output logic             pulldownOffSecondBytePort,
  output logic      [2:0]  transceiverConfigPins,
  output logic      [7:0]  powerSignalData,
  output logic             powerSignalValid,
  // interrupt
  output logic             irq
);
  localparam int IRQ_W_L = upc_pkg::IRQ_W - 1;

  logic [31:0]      pwrSig_r;
  logic [31:0]      phyCtrl_r;
  logic [IRQ_W_L:0] irqStat_r;
  logic [IRQ_W_L:0] irqMask_r;
  logic [31:0]      rdata_r;
  logic [7:0]       addr_r;
  logic             wrPend_r;
  logic             wrEn;
  logic             rdEn;
  logic             se0Ev;
  logic             kEv;
  logic             hwResume;
  logic [31:0]      rdMux;

  upc_line_if lif ();

  upc_line_filter u_filt (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .lf      (lif.filt)
  );

  assign lif.lineRaw   = lineStateRaw;
  assign lif.delayLog2 = phyCtrl_r[upc_pkg::DLY_LSB +: 4];

  // zero-wait slave; writes land one cycle after the address phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rdEn      = hsel && hready && htrans[1] && !hwrite;
  assign wrEn      = wrPend_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_r <= 1'b0;
      addr_r   <= 8'h00;
    end else begin
      wrPend_r <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
        addr_r <= haddr[7:0];
      end
    end
  end

  // hardware resume only while enabled and suspended
  assign hwResume =
    phyCtrl_r[upc_pkg::HW_RESUME_BIT] && suspended;
  assign se0Ev = hwResume && lif.lineChange
                 && lif.lineFilt == upc_pkg::LS_SE0;
  assign kEv   = hwResume && lif.lineChange
                 && lif.lineFilt == upc_pkg::LS_K;
  assign resumeReq = se0Ev || kEv;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrSig_r <= upc_pkg::RESET_VAL;
    end else if (wrEn && addr_r == upc_pkg::PWR_SIG_OFS) begin
      pwrSig_r <= hwdata & upc_pkg::PWR_SIG_MASK;
    end
  end

  // event set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phyCtrl_r <= upc_pkg::RESET_VAL;
    end else begin
      if (wrEn && addr_r == upc_pkg::PHY_CTRL_OFS) begin
        phyCtrl_r <= hwdata & upc_pkg::PHY_CTRL_MASK;
        // flags are clear-only from software: writing 1 keeps them
        phyCtrl_r[upc_pkg::SE0_FLAG_BIT] <=
          phyCtrl_r[upc_pkg::SE0_FLAG_BIT]
          && hwdata[upc_pkg::SE0_FLAG_BIT];
        phyCtrl_r[upc_pkg::K_FLAG_BIT] <=
          phyCtrl_r[upc_pkg::K_FLAG_BIT]
          && hwdata[upc_pkg::K_FLAG_BIT];
      end
      if (se0Ev) begin
        phyCtrl_r[upc_pkg::SE0_FLAG_BIT] <= 1'b1;
      end
      if (kEv) begin
        phyCtrl_r[upc_pkg::K_FLAG_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_r <= '0;
    end else begin
      if (wrEn && addr_r == upc_pkg::IRQ_STAT_OFS) begin
        irqStat_r <= irqStat_r & ~hwdata[IRQ_W_L:0];
      end
      if (se0Ev) begin
        irqStat_r[0] <= 1'b1;
      end
      if (kEv) begin
        irqStat_r[1] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqMask_r <= '0;
    end else if (wrEn && addr_r == upc_pkg::IRQ_MASK_OFS) begin
      irqMask_r <= hwdata[IRQ_W_L:0];
    end
  end

  assign irq = |(irqStat_r & irqMask_r);

  always_comb begin
    unique case (haddr[7:0])
      upc_pkg::PWR_SIG_OFS:   rdMux = pwrSig_r;
      upc_pkg::PHY_CTRL_OFS:  rdMux = phyCtrl_r;
      upc_pkg::IRQ_STAT_OFS:  rdMux = {30'h0000_0000, irqStat_r};
      upc_pkg::IRQ_MASK_OFS:  rdMux = {30'h0000_0000, irqMask_r};
      upc_pkg::LINE_STAT_OFS: rdMux = {30'h0000_0000, lif.lineFilt};
      default:                rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (rdEn) begin
      rdata_r <= rdMux;
    end
  end

  assign hrdata = rdata_r;

  assign pulldownOffFirstBytePort  =
    phyCtrl_r[upc_pkg::PD_OFF_BIT];
  assign pulldownOffSecondBytePort =
    phyCtrl_r[upc_pkg::PD_OFF_BIT];
  assign transceiverConfigPins =
    phyCtrl_r[upc_pkg::CONF_LSB +: 3];
  assign powerSignalData  = pwrSig_r[7:0];
  assign powerSignalValid = pwrSig_r[upc_pkg::PS_VALID_BIT];
endmodule

// file: test/upc_phy_model.sv
module upc_phy_model (
  // clock
  input  wire logic       ref_clk,
  // line side
  output logic      [1:0] lineStateRaw,
  output logic            suspended
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus rests in J, awake
  initial begin
    lineStateRaw = upc_pkg::LS_J;
    suspended = 1'h0;
  end
  // whole-cycle steps only: a filter sees no glitch
  task automatic drive(input logic [1:0] s, input logic p);
    @(posedge ref_clk);
    lineStateRaw <= s;
    suspended <= p;
  endtask
endmodule

// file: test/upc_regs_assertions.sv
module upc_regs_assertions (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // bus
  input wire logic       hsel,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic [1:0] htrans,
  input wire logic       hreadyout,
  input wire logic       hresp,
  // line and outputs
  input wire logic [1:0] lineStateRaw,
  input wire logic       suspended,
  input wire logic       resumeReq,
  input wire logic       powerSignalValid,
  input wire logic       pulldownOffFirstBytePort,
  input wire logic       pulldownOffSecondBytePort,
  input wire logic [2:0] transceiverConfigPins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wrReq;
  assign wrReq = hsel & hwrite & htrans[1];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr; wrReq && hready; endsequence
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus stall");
  property p_pair;
    pulldownOffFirstBytePort == pulldownOffSecondBytePort;
  endproperty
  a_pair: assert property (p_pair) else $error("pulldowns split");
  property p_pd; $changed(pulldownOffFirstBytePort) |-> $past(wrReq, 2);
  endproperty
  a_pd: assert property (p_pd) else $error("pulldown moved");
  property p_conf; $changed(transceiverConfigPins) |-> $past(wrReq, 2);
  endproperty
  a_conf: assert property (p_conf) else $error("config moved");
  property p_pwr; $changed(powerSignalValid) |-> $past(wrReq, 2); endproperty
  a_pwr: assert property (p_pwr) else $error("valid moved");
  property p_pulse; resumeReq |=> !resumeReq; endproperty
  a_pulse: assert property (p_pulse) else $error("long resume");
  property p_susp; resumeReq |-> suspended; endproperty
  a_susp: assert property (p_susp) else $error("resume awake");
  property p_notj; resumeReq |-> $past(lineStateRaw) != upc_pkg::LS_J;
  endproperty
  a_notj: assert property (p_notj) else $error("resume on J");
  c_wr: cover property (s_wr);
endmodule
bind upc_regs upc_regs_assertions u_chk (.ref_clk, .rst_n, .hsel, .hwrite,
  .hready, .htrans, .hreadyout, .hresp, .lineStateRaw, .suspended,
  .resumeReq, .powerSignalValid, .pulldownOffFirstBytePort,
  .pulldownOffSecondBytePort, .transceiverConfigPins);

// file: test/usb_phy_control_regs_tb.sv
module usb_phy_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, irq;
  logic        suspended, resumeReq, powerSignalValid;
  logic        pulldownOffFirstBytePort, pulldownOffSecondBytePort;
  logic [1:0]  htrans, lineStateRaw;
  logic [2:0]  hsize, transceiverConfigPins;
  logic [7:0]  powerSignalData;
  logic [31:0] haddr, hwdata, hrdata, q;
  int          miscompares, checks;
  upc_regs u_dut (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .lineStateRaw,
    .suspended, .resumeReq, .pulldownOffFirstBytePort, .irq,
    .pulldownOffSecondBytePort, .transceiverConfigPins, .powerSignalData,
    .powerSignalValid);
  upc_phy_model u_phy (.ref_clk, .lineStateRaw, .suspended);
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // bounded wait for hready at a rising edge
  task automatic wt;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'h1 && n < 99);
    if (hreadyout !== 1'h1) begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wt();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask
  task automatic t_rst;
    xf(upc_pkg::PHY_CTRL_OFS, 1'h0, 32'h0);
    ck(q, upc_pkg::RESET_VAL);
    ck({29'h0, transceiverConfigPins}, 32'h0);
    ck({31'h0, pulldownOffFirstBytePort}, 32'h0);
    xf(upc_pkg::PWR_SIG_OFS, 1'h0, 32'h0);
    ck(q, upc_pkg::RESET_VAL);
    xf(8'h50, 1'h1, 32'hFFFFFFFF);
    xf(8'h50, 1'h0, 32'h0);
    ck(q, 32'h0);
    $display("t_rst done");
  endtask
  task automatic t_wr;
    logic [31:0] d;
    for (int i = 0; i < 2; i++) begin
      d = i ? 32'h0 : 32'hFFFFFFFF;
      xf(upc_pkg::PWR_SIG_OFS, 1'h1, d);
      xf(upc_pkg::PHY_CTRL_OFS, 1'h1, d);
      xf(upc_pkg::PWR_SIG_OFS, 1'h0, 32'h0);
      ck(q, d & upc_pkg::PWR_SIG_MASK);
      ck({23'h0, powerSignalValid, powerSignalData}, {23'h0, d[8:0]});
      xf(upc_pkg::PHY_CTRL_OFS, 1'h0, 32'h0);
      ck(q, d & 32'h00040FF0);
      ck({29'h0, transceiverConfigPins}, {29'h0, d[6:4]});
      ck({31'h0, pulldownOffSecondBytePort}, {31'h0, d[18]});
      // unmapped read must replace a nonzero word with zero
      xf(8'h50, 1'h1, d);
      xf(8'h50, 1'h0, 32'h0);
      ck(q, 32'h0);
    end
    $display("t_wr done");
  endtask
  // hardware resume, delay field 2: four stable cycles needed
  task automatic t_res;
    int n;
    for (int k = 0; k < 2; k++) begin
      xf(upc_pkg::IRQ_MASK_OFS, 1'h1, 32'h3);
      xf(upc_pkg::PHY_CTRL_OFS, 1'h1, 32'h280);
      u_phy.drive(k ? upc_pkg::LS_K : upc_pkg::LS_SE0, 1'h1);
      n = 0;
      while (resumeReq !== 1'h1 && n < 40) begin
        @(posedge ref_clk);
        n++;
      end
      // four held cycles, one to latch, one to be sampled
      ck(32'(n), 32'h6);
      @(posedge ref_clk);
      ck({31'h0, irq}, 32'h1);
      xf(upc_pkg::PHY_CTRL_OFS, 1'h0, 32'h0);
      ck(q, k ? 32'h1280 : 32'h2280);
      xf(upc_pkg::PHY_CTRL_OFS, 1'h1, 32'h280);
      xf(upc_pkg::IRQ_STAT_OFS, 1'h1, 32'h3);
      xf(upc_pkg::PHY_CTRL_OFS, 1'h0, 32'h0);
      ck(q, 32'h280);
      ck({31'h0, irq}, 32'h0);
      u_phy.drive(upc_pkg::LS_J, 1'h0);
    end
    $display("t_res done");
  endtask
  // polled mode: line filtered, no resume raised
  task automatic t_poll;
    xf(upc_pkg::PHY_CTRL_OFS, 1'h1, 32'h200);
    // filtered state must first settle back to idle
    q = 32'h0;
    for (int i = 0; i < 9 && q !== {30'h0, upc_pkg::LS_J}; i++)
      xf(upc_pkg::LINE_STAT_OFS, 1'h0, 32'h0);
    ck(q, {30'h0, upc_pkg::LS_J});
    u_phy.drive(upc_pkg::LS_K, 1'h1);
    xf(upc_pkg::LINE_STAT_OFS, 1'h0, 32'h0);
    ck(q, {30'h0, upc_pkg::LS_J});
    for (int i = 0; i < 9 && q !== {30'h0, upc_pkg::LS_K}; i++)
      xf(upc_pkg::LINE_STAT_OFS, 1'h0, 32'h0);
    ck(q, {30'h0, upc_pkg::LS_K});
    xf(upc_pkg::PHY_CTRL_OFS, 1'h0, 32'h0);
    ck(q, 32'h200);
    ck({31'h0, irq}, 32'h0);
    $display("t_poll done");
  endtask
  initial begin
    rst_n = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    miscompares = 0;
    checks = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_rst();
    t_wr();
    t_res();
    t_poll();
    summarize();
  end
endmodule
